// ### hdl/dfm_core.sv
// Drive fault manager: error words, reactions, fault reset and LED selection
`timescale 1ns/10ps
`default_nettype none
module dfm_core #(
	parameter int unsigned LOCKOUT_CYCLES = dfm_pkg::LOCKOUT_CYCLES,
	parameter int unsigned SLOT_CYCLES    = dfm_pkg::SLOT_CYCLES
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         srst,
	// Error detection
	input  wire logic [31:0]                  warn_detect,
	input  wire logic [31:0]                  fault_detect,
	// Configuration
	input  wire logic [31:0]                  fault_action_mask,
	input  wire logic [31:0]                  safety_move_fault_mask,
	input  wire logic                         safety_move_control,
	input  wire logic [2:0]                   fault_stop_option,
	// Host commands
	input  wire logic                         enable_req,
	input  wire logic                         control_word_b7,
	input  wire logic                         warn_latched_wr,
	// Motion handshake
	input  wire logic                         reaction_done,
	// Error words
	output var  logic [31:0]                  warning_live_word,
	output var  logic [31:0]                  warning_latched_word,
	output var  logic [31:0]                  fault_live_word,
	output var  logic [31:0]                  fault_latched_word,
	output var  logic [dfm_pkg::SUM_W-1:0]    summary_error_reg,
	// Drive control
	output var  dfm_pkg::dfm_state_e          drive_state,
	output var  logic                         motor_disable,
	output var  logic                         ramp_stop,
	output var  logic                         safety_move,
	output var  logic [2:0]                   stop_option,
	// Status LEDs
	output var  dfm_pkg::dfm_color_e          led_color,
	output var  logic                         status_led_first,
	output var  logic                         status_led_second
);
	logic [31:0]                 fault_eff;
	logic [31:0]                 fault_masked;
	logic [31:0]                 new_fault;
	logic [31:0]                 safe_set;
	logic [31:0]                 ramp_set;
	logic                        safety_ok;
	logic                        fatal_hit;
	logic                        cw_b7_q;
	logic                        reset_edge;
	logic                        reset_ok;
	logic [dfm_pkg::LOCK_W-1:0]  lock_cnt_q;
	dfm_pkg::dfm_react_e         react_q;
	dfm_pkg::dfm_react_e         react_d;
	dfm_pkg::dfm_pat_e           pat_first_q;
	dfm_pkg::dfm_pat_e           pat_second_q;
	dfm_pkg::dfm_pat_e           pat_first_d;
	dfm_pkg::dfm_pat_e           pat_second_d;
	dfm_pkg::dfm_color_e         color_d;
	logic [31:0]                 fault_any;
	logic [31:0]                 warn_any;
	logic [31:0]                 live_any;

	// masked maskable faults become warnings only
	assign fault_masked = fault_detect & dfm_pkg::FAULT_MASK & dfm_pkg::MASKABLE_MASK & ~fault_action_mask;
	assign fault_eff    = fault_detect & dfm_pkg::FAULT_MASK & ~fault_masked;
	assign new_fault    = fault_eff & ~fault_live_word;

	assign safety_ok = drive_state == dfm_pkg::ST_OPERATION_ENABLED && safety_move_control;
	assign safe_set  = safety_ok ? (new_fault & dfm_pkg::SAFETY_MOVE_MASK & safety_move_fault_mask) : '0;
	assign ramp_set  = new_fault & ~dfm_pkg::FATAL_MASK & ~safe_set;
	assign fatal_hit = |(new_fault & dfm_pkg::FATAL_MASK);

	always_comb begin
		if (fatal_hit) begin
			react_d = dfm_pkg::REACT_FATAL;
		end else if (ramp_set != '0) begin
			react_d = dfm_pkg::REACT_RAMP;
		end else begin
			react_d = dfm_pkg::REACT_SAFETY;
		end
	end

	// warning words, set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			warning_live_word    <= dfm_pkg::WORD_RST;
			warning_latched_word <= dfm_pkg::WORD_RST;
		end else begin
			warning_live_word <= (warn_detect & dfm_pkg::WARN_LIVE_MASK) | fault_masked;
			warning_latched_word <= ((warn_latched_wr || (reset_ok && fault_latched_word != '0))
				? '0 : warning_latched_word) | (warn_detect & dfm_pkg::WARN_LATCH_MASK) | fault_masked;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			fault_live_word    <= dfm_pkg::WORD_RST;
			fault_latched_word <= dfm_pkg::WORD_RST;
		end else begin
			fault_live_word <= fault_eff;
			// latched faults clear only if some present
			fault_latched_word <= ((reset_ok && fault_latched_word != '0) ? '0 : fault_latched_word) | fault_eff;
		end
	end

	assign live_any = fault_live_word | warning_live_word;
	always_ff @(posedge clk) begin
		if (srst) begin
			summary_error_reg <= '0;
		end else begin
			summary_error_reg <= '0;
			summary_error_reg[dfm_pkg::SUM_GENERIC] <= live_any != '0;
			summary_error_reg[dfm_pkg::SUM_CURRENT] <= |(live_any & dfm_pkg::SUM_CURRENT_SRC);
			summary_error_reg[dfm_pkg::SUM_VOLTAGE] <= |(live_any & dfm_pkg::SUM_VOLTAGE_SRC);
			summary_error_reg[dfm_pkg::SUM_TEMP]    <= |(live_any & dfm_pkg::SUM_TEMP_SRC);
			summary_error_reg[dfm_pkg::SUM_DEVICE]  <= |(live_any & ~(dfm_pkg::SUM_CURRENT_SRC
				| dfm_pkg::SUM_VOLTAGE_SRC | dfm_pkg::SUM_TEMP_SRC));
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cw_b7_q <= 1'b0;
		end else begin
			cw_b7_q <= control_word_b7;
		end
	end
	assign reset_edge = control_word_b7 && !cw_b7_q;
	assign reset_ok   = reset_edge && drive_state == dfm_pkg::ST_FAULT && lock_cnt_q == '0;

	// lockout restarts on each short or overcurrent event
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_cnt_q <= '0;
		end else if (|(new_fault & dfm_pkg::LOCKOUT_SRC_MASK)) begin
			lock_cnt_q <= dfm_pkg::LOCK_W'(LOCKOUT_CYCLES);
		end else if (lock_cnt_q != '0) begin
			lock_cnt_q <= lock_cnt_q - 1'b1;
		end
	end

	// Drive state and motor reaction
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_state   <= dfm_pkg::ST_SWITCH_ON_DISABLED;
			react_q       <= dfm_pkg::REACT_FATAL;
			motor_disable <= 1'b1;
			ramp_stop     <= 1'b0;
			safety_move   <= 1'b0;
			stop_option   <= dfm_pkg::OPT_RST;
		end else begin
			case (drive_state)
				dfm_pkg::ST_SWITCH_ON_DISABLED, dfm_pkg::ST_OPERATION_ENABLED: begin
					if (new_fault != '0) begin
						drive_state   <= dfm_pkg::ST_FAULT_REACTION_ACTIVE;
						react_q       <= react_d;
						stop_option   <= fault_stop_option;
						motor_disable <= fatal_hit || drive_state == dfm_pkg::ST_SWITCH_ON_DISABLED;
						ramp_stop     <= react_d == dfm_pkg::REACT_RAMP
							&& drive_state == dfm_pkg::ST_OPERATION_ENABLED;
						safety_move   <= react_d == dfm_pkg::REACT_SAFETY
							&& drive_state == dfm_pkg::ST_OPERATION_ENABLED;
					end else if (drive_state == dfm_pkg::ST_SWITCH_ON_DISABLED) begin
						if (enable_req && fault_live_word == '0) begin
							drive_state   <= dfm_pkg::ST_OPERATION_ENABLED;
							motor_disable <= 1'b0;
						end
					end else if (!enable_req) begin
						drive_state   <= dfm_pkg::ST_SWITCH_ON_DISABLED;
						motor_disable <= 1'b1;
					end
				end
				dfm_pkg::ST_FAULT_REACTION_ACTIVE: begin
					// a stronger late reaction takes over
					if (fatal_hit || react_q == dfm_pkg::REACT_FATAL || motor_disable
							|| ((ramp_stop || safety_move) && reaction_done)) begin
						drive_state   <= dfm_pkg::ST_FAULT;
						motor_disable <= 1'b1;
						ramp_stop     <= 1'b0;
						safety_move   <= 1'b0;
					end else if (react_q == dfm_pkg::REACT_SAFETY && ramp_set != '0) begin
						react_q     <= dfm_pkg::REACT_RAMP;
						ramp_stop   <= 1'b1;
						safety_move <= 1'b0;
					end
				end
				dfm_pkg::ST_FAULT: begin
					// leave only when no live fault
					if (reset_ok && fault_live_word == '0 && new_fault == '0) begin
						drive_state <= dfm_pkg::ST_SWITCH_ON_DISABLED;
					end
				end
				default: begin
					drive_state   <= dfm_pkg::ST_FAULT;
					motor_disable <= 1'b1;
				end
			endcase
		end
	end

	assign fault_any = fault_latched_word | fault_live_word;
	assign warn_any  = warning_live_word | warning_latched_word;
	always_comb begin
		logic [4:0] best;
		best         = dfm_pkg::ORDER_NONE;
		color_d      = dfm_pkg::COLOR_GREEN;
		pat_first_d  = dfm_pkg::PAT_ON;
		pat_second_d = dfm_pkg::PAT_OFF;
		if (fault_latched_word != '0) begin
			color_d = dfm_pkg::COLOR_RED;
			for (int i = 0; i < 32; i++) begin
				if (fault_any[i] && dfm_pkg::LED_ORDER[i] < best) begin
					best         = dfm_pkg::LED_ORDER[i];
					pat_first_d  = dfm_pkg::LED_FIRST[i];
					pat_second_d = dfm_pkg::LED_SECOND[i];
				end
			end
		end else if (warn_any != '0) begin
			color_d = dfm_pkg::COLOR_ORANGE;
			for (int i = 0; i < 32; i++) begin
				if (warn_any[i]) begin
					pat_first_d  = dfm_pkg::LED_FIRST[i];
					pat_second_d = dfm_pkg::LED_SECOND[i];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			led_color    <= dfm_pkg::COLOR_GREEN;
			pat_first_q  <= dfm_pkg::PAT_OFF;
			pat_second_q <= dfm_pkg::PAT_OFF;
		end else begin
			led_color    <= color_d;
			pat_first_q  <= pat_first_d;
			pat_second_q <= pat_second_d;
		end
	end

	dfm_led_pattern #(
		.SLOT_CYCLES (SLOT_CYCLES)
	) u_led (
		.clk               (clk),
		.srst              (srst),
		.pat_first         (pat_first_q),
		.pat_second        (pat_second_q),
		.status_led_first  (status_led_first),
		.status_led_second (status_led_second)
	);

	sequence s_ramp_end;
		ramp_stop && reaction_done && !fatal_hit;
	endsequence
	sequence s_disabled;
		motor_disable && !ramp_stop && drive_state == dfm_pkg::ST_FAULT;
	endsequence

	chk_red_color: assert property (@(posedge clk) disable iff (srst)
		fault_latched_word != '0 |=> led_color == dfm_pkg::COLOR_RED)
		else $error("red not shown with latched faults");
	chk_green_idle: assert property (@(posedge clk) disable iff (srst)
		(fault_latched_word | warning_live_word | warning_latched_word | fault_live_word) == '0
		|=> led_color == dfm_pkg::COLOR_GREEN)
		else $error("green not shown without errors");
	chk_fault_entry: assert property (@(posedge clk) disable iff (srst)
		new_fault != '0 && drive_state == dfm_pkg::ST_OPERATION_ENABLED
		|=> drive_state == dfm_pkg::ST_FAULT_REACTION_ACTIVE)
		else $error("fault event did not enter reaction");
	chk_fatal_now: assert property (@(posedge clk) disable iff (srst)
		fatal_hit && drive_state == dfm_pkg::ST_OPERATION_ENABLED |=> motor_disable && !ramp_stop)
		else $error("fatal fault not disabled at once");
	chk_ramp_then_off: assert property (@(posedge clk) disable iff (srst)
		s_ramp_end |=> s_disabled)
		else $error("ramp end did not disable motor");
	chk_warn_no_state: assert property (@(posedge clk) disable iff (srst)
		new_fault == '0 && enable_req && drive_state == dfm_pkg::ST_OPERATION_ENABLED
		|=> drive_state == dfm_pkg::ST_OPERATION_ENABLED)
		else $error("state moved without fault");
	chk_warn_clear: assert property (@(posedge clk) disable iff (srst)
		warn_latched_wr && warn_detect == '0 && fault_masked == '0 |=> warning_latched_word == '0)
		else $error("latched warnings not cleared");
	chk_lockout_hold: assert property (@(posedge clk) disable iff (srst)
		drive_state == dfm_pkg::ST_FAULT && lock_cnt_q != '0 |=> drive_state == dfm_pkg::ST_FAULT)
		else $error("reset taken during lockout");
	chk_reset_exit: assert property (@(posedge clk) disable iff (srst)
		reset_ok && fault_live_word == '0 && new_fault == '0
		|=> drive_state == dfm_pkg::ST_SWITCH_ON_DISABLED && fault_latched_word == '0)
		else $error("fault reset did not leave fault");
	chk_summary_zero: assert property (@(posedge clk) disable iff (srst)
		live_any == '0 |=> summary_error_reg == '0)
		else $error("summary bits stuck without cause");

endmodule
`default_nettype wire

// ### hdl/dfm_pkg.sv
// Constants, tables and types for the drive fault manager
package dfm_pkg;

	localparam int unsigned ERR_W = 32;

	// Clock and long timings
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned LOCKOUT_S      = 20;
	localparam int unsigned LOCKOUT_CYCLES = LOCKOUT_S * CLK_HZ;
	localparam int unsigned LOCK_W         = 29;
	localparam int unsigned SLOT_MS        = 125;
	localparam int unsigned SLOT_CYCLES    = (CLK_HZ / 1000) * SLOT_MS;
	localparam int unsigned SLOT_W         = 22;

	// Per-bit error properties
	localparam logic [31:0] WARN_LIVE_MASK    = 32'h0e73346b;
	localparam logic [31:0] WARN_LATCH_MASK   = 32'h0b63340b;
	localparam logic [31:0] FAULT_MASK        = 32'h9381f4db;
	localparam logic [31:0] MASKABLE_MASK     = 32'h12019088;
	localparam logic [31:0] SAFETY_MOVE_MASK  = 32'h0301b0c0;
	localparam logic [31:0] FATAL_MASK        = 32'h10804419;
	localparam logic [31:0] SELF_RESTORE_MASK = 32'h00000008;
	localparam logic [31:0] LOCKOUT_SRC_MASK  = 32'h00000410;

	// Summary error register layout
	localparam int unsigned SUM_W         = 8;
	localparam int unsigned SUM_GENERIC   = 0;
	localparam int unsigned SUM_CURRENT   = 1;
	localparam int unsigned SUM_VOLTAGE   = 2;
	localparam int unsigned SUM_TEMP      = 3;
	localparam int unsigned SUM_DEVICE    = 7;
	localparam logic [31:0] SUM_CURRENT_SRC = 32'h00000410;
	localparam logic [31:0] SUM_VOLTAGE_SRC = 32'h02000009;
	localparam logic [31:0] SUM_TEMP_SRC    = 32'h08000002;

	// Reset values
	localparam logic [31:0] WORD_RST = 32'h00000000;
	localparam logic [2:0]  OPT_RST  = 3'h0;

	typedef enum logic [2:0] {PAT_OFF, PAT_ON, PAT_BLK, PAT_FL1, PAT_FL2, PAT_FL3} dfm_pat_e;
	typedef enum logic [1:0] {COLOR_GREEN, COLOR_ORANGE, COLOR_RED} dfm_color_e;
	typedef enum logic [1:0] {ST_SWITCH_ON_DISABLED, ST_OPERATION_ENABLED,
		ST_FAULT_REACTION_ACTIVE, ST_FAULT} dfm_state_e;
	typedef enum logic [1:0] {REACT_FATAL, REACT_RAMP, REACT_SAFETY} dfm_react_e;

	// Display order per error bit, 31 marks no entry
	localparam logic [4:0] ORDER_NONE = 5'h1f;
	localparam logic [4:0] LED_ORDER [32] = '{
		5'h00, 5'h03, 5'h1f, 5'h04, 5'h01, 5'h11, 5'h09, 5'h0c,
		5'h1f, 5'h1f, 5'h02, 5'h1f, 5'h0d, 5'h08, 5'h06, 5'h15,
		5'h0f, 5'h10, 5'h1f, 5'h1f, 5'h0e, 5'h12, 5'h16, 5'h07,
		5'h0a, 5'h05, 5'h13, 5'h14, 5'h17, 5'h1f, 5'h1f, 5'h18};
	localparam dfm_pat_e LED_FIRST [32] = '{
		PAT_ON,  PAT_ON,  PAT_OFF, PAT_ON,  PAT_ON,  PAT_FL2, PAT_BLK, PAT_FL1,
		PAT_OFF, PAT_OFF, PAT_ON,  PAT_OFF, PAT_FL1, PAT_BLK, PAT_BLK, PAT_FL2,
		PAT_FL1, PAT_FL1, PAT_OFF, PAT_OFF, PAT_FL1, PAT_FL2, PAT_BLK, PAT_BLK,
		PAT_BLK, PAT_ON,  PAT_FL2, PAT_BLK, PAT_FL3, PAT_OFF, PAT_OFF, PAT_FL3};
	localparam dfm_pat_e LED_SECOND [32] = '{
		PAT_BLK, PAT_FL1, PAT_OFF, PAT_FL2, PAT_ON,  PAT_BLK, PAT_FL2, PAT_BLK,
		PAT_OFF, PAT_OFF, PAT_ON,  PAT_OFF, PAT_FL1, PAT_FL1, PAT_ON,  PAT_ON,
		PAT_FL3, PAT_FL3, PAT_OFF, PAT_OFF, PAT_FL2, PAT_FL1, PAT_ON,  PAT_BLK,
		PAT_FL3, PAT_FL3, PAT_FL2, PAT_FL3, PAT_FL1, PAT_OFF, PAT_OFF, PAT_ON};

endpackage

// ### hdl/dfm_led_pattern.sv
// Blink and flash-burst generator for the two status LEDs
`timescale 1ns/10ps
`default_nettype none
module dfm_led_pattern #(
	parameter int unsigned SLOT_CYCLES = dfm_pkg::SLOT_CYCLES
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            srst,
	// Selected patterns
	input  wire dfm_pkg::dfm_pat_e pat_first,
	input  wire dfm_pkg::dfm_pat_e pat_second,
	// LED drive
	output var  logic            status_led_first,
	output var  logic            status_led_second
);
	logic [dfm_pkg::SLOT_W-1:0] slot_cnt_q;
	logic [2:0]                 slot_q;
	wire  [1:0]                 led_d;

	always_ff @(posedge clk) begin
		if (srst || slot_cnt_q == dfm_pkg::SLOT_W'(SLOT_CYCLES - 1)) begin
			slot_cnt_q <= '0;
		end else begin
			slot_cnt_q <= slot_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			slot_q <= 3'h0;
		end else if (slot_cnt_q == dfm_pkg::SLOT_W'(SLOT_CYCLES - 1)) begin
			slot_q <= slot_q + 3'h1;
		end
	end

	// pattern decode, bursts of n flashes in even slots
	for (genvar i = 0; i < 2; i++) begin : g_led
		dfm_pkg::dfm_pat_e pat_sel;
		logic              bit_d;

		assign pat_sel = (i == 0) ? pat_first : pat_second;
		always_comb begin
			case (pat_sel)
				dfm_pkg::PAT_ON:  bit_d = 1'b1;
				dfm_pkg::PAT_BLK: bit_d = ~slot_q[2];
				dfm_pkg::PAT_FL1: bit_d = ~slot_q[0] && slot_q[2:1] < 2'h1;
				dfm_pkg::PAT_FL2: bit_d = ~slot_q[0] && slot_q[2:1] < 2'h2;
				dfm_pkg::PAT_FL3: bit_d = ~slot_q[0] && slot_q[2:1] < 2'h3;
				default:          bit_d = 1'b0;
			endcase
		end
		// One process per bit keeps a single driver per LED
		assign led_d[i] = bit_d;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			status_led_first  <= 1'b0;
			status_led_second <= 1'b0;
		end else begin
			status_led_first  <= led_d[0];
			status_led_second <= led_d[1];
		end
	end

endmodule
`default_nettype wire

// ### sim/dfm_host_model.sv
// Host and motion side partner: fault reset edges, latched warning writes, reaction completion
`timescale 1ns/10ps
`default_nettype none
module dfm_host_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Bench requests
	input  wire logic       reset_req,
	input  wire logic       wipe_req,
	input  wire logic [3:0] done_delay,
	// Motion requests from the block
	input  wire logic       ramp_stop,
	input  wire logic       safety_move,
	// Host and motion outputs
	output var  logic       control_word_b7,
	output var  logic       warn_latched_wr,
	output var  logic       reaction_done
);
	logic [3:0] wait_q;

	always_ff @(posedge clk) begin
		if (srst)
			control_word_b7 <= 1'b0;
		else
			control_word_b7 <= reset_req;
	end

	always_ff @(posedge clk) begin
		if (srst)
			warn_latched_wr <= 1'b0;
		else
			warn_latched_wr <= wipe_req;
	end

	// Delay sets prompt or slow completion; saturates so done fires once for delays 0 to 14 and stays high at 15
	always_ff @(posedge clk) begin
		if (srst || !(ramp_stop || safety_move)) begin
			wait_q <= 4'h0;
			reaction_done <= 1'b0;
		end else begin
			if (wait_q != 4'hf)
				wait_q <= wait_q + 4'h1;
			reaction_done <= (wait_q == done_delay);
		end
	end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking testbench for the drive fault manager
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct {int kind; logic [31:0] exp;} dfm_note_s;
	localparam int LOCK = 200;
	localparam int K_ST = 0, K_WL = 1, K_WT = 2, K_FL = 3, K_FT = 4, K_SUM = 5;
	localparam int K_COL = 6, K_MOT = 7, K_OPT = 8, K_LED = 9;
	logic clk = 1'b0;
	logic srst, safety_move_control, enable_req, reset_req, wipe_req, b7, wr, done;
	logic [31:0] warn_detect, fault_detect, fault_action_mask, safety_move_fault_mask;
	logic [2:0] fault_stop_option, stop_option, opt;
	logic [3:0] done_delay;
	logic [31:0] wlive, wlat, flive, flat;
	logic [7:0] summary_error_reg;
	dfm_pkg::dfm_state_e drive_state;
	dfm_pkg::dfm_color_e led_color;
	logic motor_disable, ramp_stop, safety_move, led1, led2;
	logic [15:0] led_a, led_b;
	int err_total, num_checks, seed, wb;
	dfm_note_s q[$];
	dfm_note_s n_q;
	event chk_ev;
	logic [31:0] fb_t [5] = '{32'h2, 32'h1000, 32'h1000, 32'h1000, 32'h1002};
	logic ctl_t [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic sm_t [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
	logic [2:0] mo_t [5] = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h2};

	always #20 clk = ~clk;

	dfm_core #(.LOCKOUT_CYCLES(LOCK), .SLOT_CYCLES(4)) u_dfm_core (.clk(clk), .srst(srst),
		.warn_detect(warn_detect), .fault_detect(fault_detect), .fault_action_mask(fault_action_mask),
		.safety_move_fault_mask(safety_move_fault_mask), .safety_move_control(safety_move_control),
		.fault_stop_option(fault_stop_option), .enable_req(enable_req), .control_word_b7(b7),
		.warn_latched_wr(wr), .reaction_done(done), .warning_live_word(wlive), .warning_latched_word(wlat),
		.fault_live_word(flive), .fault_latched_word(flat), .summary_error_reg(summary_error_reg),
		.drive_state(drive_state), .motor_disable(motor_disable), .ramp_stop(ramp_stop),
		.safety_move(safety_move), .stop_option(stop_option), .led_color(led_color),
		.status_led_first(led1), .status_led_second(led2));

	dfm_host_model u_dfm_host_model (.clk(clk), .srst(srst), .reset_req(reset_req), .wipe_req(wipe_req),
		.done_delay(done_delay), .ramp_stop(ramp_stop), .safety_move(safety_move),
		.control_word_b7(b7), .warn_latched_wr(wr), .reaction_done(done));

	function automatic logic [7:0] exp_sum(input logic [31:0] f);
		logic [31:0] known;
		known = dfm_pkg::SUM_CURRENT_SRC | dfm_pkg::SUM_VOLTAGE_SRC | dfm_pkg::SUM_TEMP_SRC;
		return {|(f & ~known), 3'h0, |(f & dfm_pkg::SUM_TEMP_SRC), |(f & dfm_pkg::SUM_VOLTAGE_SRC),
			|(f & dfm_pkg::SUM_CURRENT_SRC), |f};
	endfunction

	// Lit cycles of a pattern over one 8-slot frame of 4 cycles
	function automatic logic [15:0] pat_cnt(input dfm_pkg::dfm_pat_e p);
		case (p)
			dfm_pkg::PAT_ON:  return 16'h20;
			dfm_pkg::PAT_BLK: return 16'h10;
			dfm_pkg::PAT_FL1: return 16'h4;
			dfm_pkg::PAT_FL2: return 16'h8;
			dfm_pkg::PAT_FL3: return 16'hc;
			default:          return 16'h0;
		endcase
	endfunction

	function automatic logic [31:0] out_of(input int k);
		case (k)
			K_WL: return wlive;
			K_WT: return wlat;
			K_FL: return flive;
			K_FT: return flat;
			K_SUM: return {24'h0, summary_error_reg};
			K_COL: return {30'h0, led_color};
			K_MOT: return {29'h0, motor_disable, ramp_stop, safety_move};
			K_OPT: return {29'h0, stop_option};
			default: return {led_a, led_b};
		endcase
	endfunction

	task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp, input int k);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t kind %0d got %h expected %h", $time, k, got, exp);
		end
	endtask

	task automatic cmp_state(input dfm_pkg::dfm_state_e got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t drive state %0d expected %0d", $time, got, exp);
		end
	endtask

	always begin
		@(chk_ev);
		while (q.size() > 0) begin
			n_q = q.pop_front();
			if (n_q.kind == K_ST)
				cmp_state(drive_state, n_q.exp[1:0]);
			else
				cmp_vec(out_of(n_q.kind), n_q.exp, n_q.kind);
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic note(input int k, input logic [31:0] v);
		q.push_back('{k, v});
	endtask

	task automatic check();
		#1;
		->chk_ev;
	endtask

	task automatic pulse_reset();
		reset_req <= 1'b1;
		cyc(1);
		reset_req <= 1'b0;
		cyc(3);
	endtask

	// Blink is half of any frame, so phase does not matter
	task automatic led_frame();
		led_a = 16'h0;
		led_b = 16'h0;
		repeat (32) begin
			@(posedge clk);
			#1;
			led_a += 16'(led1);
			led_b += 16'(led2);
		end
	endtask

	task automatic recover();
		fault_detect <= 32'h0;
		enable_req <= 1'b0;
		cyc(3);
		pulse_reset();
		note(K_ST, dfm_pkg::ST_SWITCH_ON_DISABLED);
		note(K_FT, 32'h0);
		check();
		enable_req <= 1'b1;
		cyc(3);
		note(K_ST, dfm_pkg::ST_OPERATION_ENABLED);
		check();
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(40 * 5000);
		err_total++;
		$display("BAD t=%0t watchdog expired", $time);
		final_report();
	end

	initial begin
		seed = 41032;
		srst <= 1'b1;
		warn_detect <= 32'h0;
		fault_detect <= 32'h0;
		fault_action_mask <= 32'hffffffff;
		safety_move_fault_mask <= 32'hffffffff;
		safety_move_control <= 1'b0;
		fault_stop_option <= 3'h0;
		enable_req <= 1'b0;
		reset_req <= 1'b0;
		wipe_req <= 1'b0;
		done_delay <= 4'h3;
		cyc(4);
		srst <= 1'b0;
		cyc(2);
		note(K_ST, dfm_pkg::ST_SWITCH_ON_DISABLED);
		note(K_MOT, 32'h4);
		note(K_FT, 32'h0);
		note(K_WT, 32'h0);
		note(K_COL, dfm_pkg::COLOR_GREEN);
		led_frame();
		note(K_LED, {16'd32, 16'd0});
		check();
		$display("test reset done");
		do wb = $unsigned($random(seed)) % 32;
		while (!(dfm_pkg::WARN_LIVE_MASK[wb] && dfm_pkg::WARN_LATCH_MASK[wb]) || wb == 0);
		// Bit 0 has the best order, so the pattern shows MSB, not priority
		warn_detect <= (32'h1 << wb) | 32'h1;
		cyc(3);
		note(K_WL, (32'h1 << wb) | 32'h1);
		note(K_WT, (32'h1 << wb) | 32'h1);
		note(K_ST, dfm_pkg::ST_SWITCH_ON_DISABLED);
		note(K_COL, dfm_pkg::COLOR_ORANGE);
		check();
		led_frame();
		note(K_LED, {pat_cnt(dfm_pkg::LED_FIRST[wb]), pat_cnt(dfm_pkg::LED_SECOND[wb])});
		check();
		warn_detect <= 32'h0;
		cyc(3);
		note(K_WL, 32'h0);
		note(K_WT, (32'h1 << wb) | 32'h1);
		note(K_COL, dfm_pkg::COLOR_ORANGE);
		check();
		wipe_req <= 1'b1;
		cyc(1);
		wipe_req <= 1'b0;
		cyc(3);
		note(K_WT, 32'h0);
		note(K_COL, dfm_pkg::COLOR_GREEN);
		check();
		$display("test warnings done");
		enable_req <= 1'b1;
		fault_action_mask <= 32'hffffff7f;
		fault_detect <= 32'h80;
		cyc(4);
		note(K_ST, dfm_pkg::ST_OPERATION_ENABLED);
		note(K_FL, 32'h0);
		note(K_WL, 32'h80);
		note(K_MOT, 32'h0);
		check();
		fault_detect <= 32'h0;
		fault_action_mask <= 32'hffffffff;
		cyc(2);
		$display("test masked fault done");
		for (int i = 0; i < 5; i++) begin
			safety_move_control <= ctl_t[i];
			safety_move_fault_mask <= sm_t[i] ? 32'hffffffff : 32'hffffefff;
			opt = 3'($random(seed));
			fault_stop_option <= opt;
			done_delay <= 4'h3 + 4'(i * 2);
			fault_detect <= fb_t[i];
			cyc(2);
			note(K_ST, dfm_pkg::ST_FAULT_REACTION_ACTIVE);
			note(K_MOT, mo_t[i]);
			note(K_OPT, opt);
			check();
			cyc(14);
			note(K_ST, dfm_pkg::ST_FAULT);
			note(K_MOT, 32'h4);
			note(K_FT, fb_t[i]);
			note(K_SUM, exp_sum(fb_t[i]));
			note(K_COL, dfm_pkg::COLOR_RED);
			check();
			pulse_reset();
			note(K_ST, dfm_pkg::ST_FAULT);
			check();
			fault_detect <= 32'h0;
			cyc(3);
			note(K_FL, 32'h0);
			note(K_SUM, 32'h0);
			check();
			recover();
			$display("test reaction %0d done", i);
		end
		fault_detect <= 32'h12;
		cyc(2);
		note(K_MOT, 32'h4);
		check();
		cyc(40);
		note(K_ST, dfm_pkg::ST_FAULT);
		led_frame();
		note(K_LED, {16'd32, 16'd32});
		check();
		fault_detect <= 32'h0;
		enable_req <= 1'b0;
		cyc(2);
		pulse_reset();
		note(K_ST, dfm_pkg::ST_FAULT);
		note(K_FT, 32'h12);
		check();
		cyc(LOCK + 10);
		recover();
		$display("test lockout done");
		fault_detect <= 32'h1;
		cyc(40);
		led_frame();
		note(K_LED, {16'd32, 16'd16});
		check();
		recover();
		$display("test overvoltage done");
		cyc(1);
		final_report();
	end
endmodule
`default_nettype wire
